// ==== rtl/ctc_calib.sv ====
// Current and temperature calibration datapath with AXI4-Lite registers
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ctc_defs.svh"

module ctc_calib (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]            s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire ctc_pkg::ctc_word_type s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output ctc_pkg::ctc_word_type      s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Raw counter samples of the sense input difference
  input  wire ctc_pkg::ctc_word_type cc_count_i,
  input  wire logic                  cc_valid_i,
  // Computed temperatures in 0.1 K
  input  wire ctc_pkg::ctc_temp_type temp_raw_i,
  input  wire logic [3:0]            temp_src_i,
  input  wire logic                  temp_valid_i,
  // Corrected results
  output ctc_pkg::ctc_word_type      current_o,
  output logic                       current_valid_o,
  output ctc_pkg::ctc_word_type      charge_o,
  output ctc_pkg::ctc_temp_type      temp_o,
  output logic [3:0]                 temp_src_o,
  output logic                       temp_valid_o
);
  import ctc_pkg::*;

  ctc_state_type      q;
  ctc_state_type      n;
  logic               aw_fire;
  logic               w_fire;
  logic               wr_go;
  logic [7:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               chg_clr;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic signed [31:0] divisor;
  logic signed [31:0] cur_prod;
  logic signed [31:0] cap_prod;
  logic [15:0]        temp_ofs_sel;

  function automatic logic [31:0] ctc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic ctc_temp_hit(input logic [7:0] a);
    return (a >= `CTC_REG_TEMP_BASE) && (a < `CTC_REG_TEMP_END)
           && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] ctc_temp_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - `CTC_REG_TEMP_BASE;
    return off[5:2];
  endfunction

  // Current and charge paths: one multiplier per gain
  ctc_fmul u_cur_mul (
    .count_i (q.corr),
    .gain_i  (q.cur_gain),
    .shift_i (q.cur_shift),
    .prod_o  (cur_prod)
  );

  ctc_fmul u_cap_mul (
    .count_i (q.corr),
    .gain_i  (q.cap_gain),
    .shift_i (q.cap_shift),
    .prod_o  (cap_prod)
  );

  // Handshake outputs
  assign s_axi_awready_o = !q.aw_held && !q.bvalid;
  assign s_axi_wready_o  = !q.w_held && !q.bvalid;
  assign s_axi_arready_o = !q.rvalid;
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire  = s_axi_wvalid_i && s_axi_wready_o;
  assign wr_go   = (q.aw_held || aw_fire) && (q.w_held || w_fire)
                   && !q.bvalid;
  assign wr_addr = q.aw_held ? q.awaddr : s_axi_awaddr_i;
  assign wr_data = q.w_held ? q.wdata : s_axi_wdata_i;
  assign wr_strb = q.w_held ? q.wstrb : s_axi_wstrb_i;
  assign chg_clr = wr_go && (wr_addr == `CTC_REG_CHARGE);
  // A zero sample count is treated as one
  assign divisor = (q.samples == 16'h0000) ? 32'sh00000001
                                           : $signed({16'h0000, q.samples});
  assign temp_ofs_sel = (temp_src_i < `CTC_TEMP_SRCS)
                        ? q.temp_ofs[temp_src_i] : 16'h0000;

  // Read decode
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case (s_axi_araddr_i)
      `CTC_REG_CURRENT_OFFSET_CONST:   rd_data = q.current_offset_const;
      `CTC_REG_OFS_SAMPLES: rd_data = {16'h0000, q.samples};
      `CTC_REG_CUR_GAIN:    rd_data = q.cur_gain;
      `CTC_REG_CAP_GAIN:    rd_data = q.cap_gain;
      `CTC_REG_UNIT_SHIFT: begin
        rd_data[`CTC_CUR_SHIFT_LSB +: 5] = q.cur_shift;
        rd_data[`CTC_CAP_SHIFT_LSB +: 5] = q.cap_shift;
      end
      `CTC_REG_CURRENT:     rd_data = q.current;
      `CTC_REG_CHARGE:      rd_data = q.charge;
      default: begin
        if (ctc_temp_hit(s_axi_araddr_i)) begin
          rd_data = {16'h0000, q.temp_ofs[ctc_temp_idx(s_axi_araddr_i)]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    n = q;
    // Write channel
    if (aw_fire) begin
      n.aw_held = 1'b1;
      n.awaddr  = s_axi_awaddr_i;
    end
    if (w_fire) begin
      n.w_held = 1'b1;
      n.wdata  = s_axi_wdata_i;
      n.wstrb  = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `CTC_RESP_OKAY;
      case (wr_addr)
        `CTC_REG_CURRENT_OFFSET_CONST:
          n.current_offset_const = ctc_merge(q.current_offset_const, wr_data, wr_strb);
        `CTC_REG_OFS_SAMPLES:
          n.samples = 16'(ctc_merge({16'h0000, q.samples}, wr_data,
                                    wr_strb));
        `CTC_REG_CUR_GAIN:
          n.cur_gain = ctc_merge(q.cur_gain, wr_data, wr_strb);
        `CTC_REG_CAP_GAIN:
          n.cap_gain = ctc_merge(q.cap_gain, wr_data, wr_strb);
        `CTC_REG_UNIT_SHIFT: begin
          if (wr_strb[0]) begin
            n.cur_shift = wr_data[`CTC_CUR_SHIFT_LSB +: 5];
          end
          if (wr_strb[1]) begin
            n.cap_shift = wr_data[`CTC_CAP_SHIFT_LSB +: 5];
          end
        end
        `CTC_REG_CURRENT:     n.bresp = `CTC_RESP_SLVERR;
        `CTC_REG_CHARGE:      n.charge = 32'sh00000000;
        default: begin
          if (ctc_temp_hit(wr_addr)) begin
            n.temp_ofs[ctc_temp_idx(wr_addr)] =
              16'(ctc_merge({16'h0000, q.temp_ofs[ctc_temp_idx(wr_addr)]},
                            wr_data, wr_strb));
          end else begin
            n.bresp = `CTC_RESP_SLVERR;
          end
        end
      endcase
    end
    // Read channel
    if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_data;
      n.rresp  = rd_ok ? `CTC_RESP_OKAY : `CTC_RESP_SLVERR;
    end
    // Offset per sample, refreshed every cycle from the stored settings
    n.quot = q.current_offset_const / divisor;
    // Stage 1: offset removal on the raw sense reading
    n.corr_valid = cc_valid_i;
    if (cc_valid_i) begin
      n.corr = $signed(cc_count_i) - q.quot;
    end
    // Stage 2: gains applied, charge accumulated; a clear with a sample restarts the charge from that sample
    n.current_valid = q.corr_valid;
    if (q.corr_valid) begin
      n.current = cur_prod;
      n.charge  = (chg_clr ? 32'sh00000000 : q.charge) + cap_prod;
    end
    // Temperature: offset of the reporting source only, in 0.1 K steps
    n.temp_valid = temp_valid_i;
    if (temp_valid_i) begin
      n.temp     = $signed(temp_raw_i) + $signed(temp_ofs_sel);
      n.temp_src = temp_src_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q           <= '0;
      q.samples   <= `CTC_RST_SAMPLES;
      q.cur_gain  <= `CTC_RST_GAIN;
      q.cap_gain  <= `CTC_RST_GAIN;
      q.cur_shift <= `CTC_RST_SHIFT;
      q.cap_shift <= `CTC_RST_SHIFT;
    end else begin
      q <= n;
    end
  end

  assign s_axi_bvalid_o  = q.bvalid;
  assign s_axi_bresp_o   = q.bresp;
  assign s_axi_rvalid_o  = q.rvalid;
  assign s_axi_rdata_o   = q.rdata;
  assign s_axi_rresp_o   = q.rresp;
  assign current_o       = q.current;
  assign current_valid_o = q.current_valid;
  assign charge_o        = q.charge;
  assign temp_o          = q.temp;
  assign temp_src_o      = q.temp_src;
  assign temp_valid_o    = q.temp_valid;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_sample_in;
    cc_valid_i;
  endsequence

  sequence s_result_out;
    current_valid_o ##0 (current_o == $past(q.corr));
  endsequence

  a_offset_removed: assert property (
    cc_valid_i |=> (q.corr == $signed($past(cc_count_i)) - $past(q.quot)))
    else $error("offset not removed from raw count");

  a_result_latency: assert property (
    s_sample_in |-> ##2 current_valid_o)
    else $error("current result missing two cycles after sample");

  a_unity_gain: assert property (
    (q.corr_valid && q.cur_gain == `CTC_FP_ONE
     && q.cur_shift == `CTC_RST_SHIFT) |=> s_result_out)
    else $error("unity gain changed the corrected count");

  a_charge_accum: assert property (
    (q.corr_valid && !chg_clr)
    |=> (charge_o == $past(q.charge) + $past(cap_prod)))
    else $error("charge did not accumulate capacity product");

  a_zero_exponent: assert property (
    (q.corr_valid && q.cur_gain[30:23] == 8'h00)
    |=> (current_o == 32'h0))
    else $error("zero gain exponent gave nonzero current");

  a_temp_offset: assert property (
    (temp_valid_i && temp_src_i < `CTC_TEMP_SRCS)
    |=> (temp_o == 16'($past(temp_raw_i) + $past(temp_ofs_sel))))
    else $error("temperature offset not added");

  a_temp_source: assert property (
    (temp_valid_i && temp_src_i >= `CTC_TEMP_SRCS)
    |=> (temp_o == $past(temp_raw_i)) && (temp_src_o == $past(temp_src_i)))
    else $error("unknown source received an offset");

  a_temp_step: assert property (
    (temp_valid_i && temp_ofs_sel == 16'h0001)
    |=> (temp_o == 16'($past(temp_raw_i) + 16'h0001)))
    else $error("one offset step is not one tenth kelvin");

  a_signed_corr: assert property (
    (cc_valid_i && cc_count_i[31] && !cc_count_i[30] && q.quot == 32'sh0)
    |=> (q.corr < 32'sh00000000))
    else $error("negative count lost its sign");

endmodule // ctc_calib
`default_nettype wire

// ==== rtl/ctc_defs.svh ====
// Register map, reset values and arithmetic constants of the calibration block
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH

`define CTC_REG_CURRENT_OFFSET_CONST   8'h00
`define CTC_REG_OFS_SAMPLES 8'h04
`define CTC_REG_CUR_GAIN    8'h08
`define CTC_REG_CAP_GAIN    8'h0c
`define CTC_REG_UNIT_SHIFT  8'h10
`define CTC_REG_CURRENT     8'h14
`define CTC_REG_CHARGE      8'h18
`define CTC_REG_TEMP_BASE   8'h20
`define CTC_REG_TEMP_END    8'h48

`define CTC_TEMP_SRCS       4'ha
`define CTC_CUR_SHIFT_LSB   0
`define CTC_CAP_SHIFT_LSB   8

`define CTC_RST_SAMPLES     16'h0001
`define CTC_RST_GAIN        32'h3f800000
`define CTC_RST_SHIFT       5'h00
`define CTC_FP_ONE          32'h3f800000

`define CTC_RESP_OKAY       2'h0
`define CTC_RESP_SLVERR     2'h2

`define CTC_FP_BIAS         11'sh096
`define CTC_FP_EXP_INF      8'hff
`define CTC_FP_SHL_MAX      11'sh01f
`define CTC_FP_SHR_MAX      11'sh038
`define CTC_MAG_MAX         31'h7fffffff

`endif

// ==== rtl/ctc_fmul.sv ====
// Signed count times single-precision gain, scaled down by a power of two
`timescale 1ns/10ps
`default_nettype none
`include "ctc_defs.svh"

module ctc_fmul (
  // Operands
  input  wire logic signed [31:0] count_i,
  input  wire logic [31:0]        gain_i,
  input  wire logic [4:0]         shift_i,
  // Product, saturated to the signed 32-bit range
  output logic signed [31:0]      prod_o
);
  import ctc_pkg::*;

  logic [31:0]        mag;
  logic [55:0]        mant_prod;
  logic [87:0]        wide;
  logic signed [10:0] expo;
  logic               neg;
  logic               sat;
  logic [30:0]        res;

  always_comb begin
    mag       = count_i[31] ? 32'(-count_i) : count_i;
    mant_prod = 56'(mag) * 56'({1'b1, gain_i[22:0]});
    expo      = $signed({3'h0, gain_i[30:23]}) - `CTC_FP_BIAS
                - $signed({6'h00, shift_i});
    neg       = count_i[31] ^ gain_i[31];
    wide      = 88'h0;
    sat       = (gain_i[30:23] == `CTC_FP_EXP_INF);
    if (expo >= 11'sh000) begin
      if (expo > `CTC_FP_SHL_MAX) begin
        sat = 1'b1;
      end else begin
        wide = 88'(mant_prod) << expo[4:0];
      end
    end else if (expo > -`CTC_FP_SHR_MAX) begin
      wide = 88'(mant_prod >> 6'(-expo));
    end
    // Anything above bit 30 cannot be shown as a signed word
    if (|wide[87:31]) begin
      sat = 1'b1;
    end
    res = sat ? `CTC_MAG_MAX : wide[30:0];
    // Zero and subnormal gains give zero
    if (gain_i[30:23] == 8'h00 || mag == 32'h0) begin
      res = 31'h0;
    end
    prod_o = neg ? 32'(-{1'b0, res}) : {1'b0, res};
  end

endmodule // ctc_fmul
`default_nettype wire

// ==== rtl/ctc_pkg.sv ====
// Types shared by the calibration block files
`default_nettype none
package ctc_pkg;
`include "ctc_defs.svh"

  typedef logic [31:0] ctc_word_type;
  typedef logic [15:0] ctc_temp_type;

  typedef struct packed {
    logic               aw_held;
    logic [7:0]         awaddr;
    logic               w_held;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic signed [31:0] current_offset_const;
    logic [15:0]        samples;
    logic [31:0]        cur_gain;
    logic [31:0]        cap_gain;
    logic [4:0]         cur_shift;
    logic [4:0]         cap_shift;
    logic signed [31:0] quot;
    logic signed [31:0] corr;
    logic               corr_valid;
    logic signed [31:0] current;
    logic               current_valid;
    logic signed [31:0] charge;
    logic [9:0][15:0]   temp_ofs;
    logic signed [15:0] temp;
    logic [3:0]         temp_src;
    logic               temp_valid;
  } ctc_state_type;
endpackage
`default_nettype wire

// ==== testbench/current_temp_calibration_tb_top.sv ====
// Self-checking bench for the current and temperature calibration block
`timescale 1ns/10ps
`default_nettype none
module current_temp_calibration_tb_top;
  import ctc_pkg::*;

  logic         clock_i;
  logic         sys_rst_i;
  logic [7:0]   awaddr;
  logic [7:0]   araddr;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp;
  logic [1:0]   rresp;
  logic [3:0]   wstrb;
  logic [3:0]   tsrc;
  logic [3:0]   tsrc_o;
  ctc_word_type wdata, rdata, cc_count, cur_o, chg_o;
  ctc_temp_type traw;
  ctc_temp_type temp_o;
  logic         cc_valid, cur_valid, tvalid, tvalid_o;
  int           failures;
  int           checks_done;
  int           i;
  logic [15:0]  ofs;

  ctc_calib dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .cc_count_i(cc_count),
    .cc_valid_i(cc_valid), .temp_raw_i(traw), .temp_src_i(tsrc),
    .temp_valid_i(tvalid), .current_o(cur_o),
    .current_valid_o(cur_valid), .charge_o(chg_o), .temp_o(temp_o),
    .temp_src_o(tsrc_o), .temp_valid_o(tvalid_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Handshake state is sampled at the falling edge, stable up to the next rise
  task automatic wr(input logic [7:0] a, input ctc_word_type d,
                    input logic [3:0] s, input logic [1:0] er);
    logic       aw_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] resp;
    int         n;
    @(posedge clock_i);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_ok = 1'b0;
    for (n = 0; n < 20 && !b_ok; n++) begin
      @(negedge clock_i);
      aw_ok = (awvalid && awready) === 1'b1;
      w_ok  = (wvalid && wready) === 1'b1;
      b_ok  = (bready && bvalid) === 1'b1;
      resp  = bresp;
      @(posedge clock_i);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
    check({30'h0, resp}, {30'h0, er});
    if (!b_ok) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, input ctc_word_type ed,
                    input logic [1:0] er);
    logic         ar_ok;
    logic         r_ok;
    logic [1:0]   resp;
    ctc_word_type data;
    int           n;
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_ok = 1'b0;
    for (n = 0; n < 20 && !r_ok; n++) begin
      @(negedge clock_i);
      ar_ok = (arvalid && arready) === 1'b1;
      r_ok  = (rready && rvalid) === 1'b1;
      resp  = rresp;
      data  = rdata;
      @(posedge clock_i);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
    check(data, ed);
    check({30'h0, resp}, {30'h0, er});
    if (!r_ok) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic cc_sample(input ctc_word_type c, input ctc_word_type ecur,
                           input ctc_word_type echg);
    int n;
    @(posedge clock_i);
    cc_count <= c;
    cc_valid <= 1'b1;
    @(posedge clock_i);
    cc_valid <= 1'b0;
    #1;
    for (n = 0; n < 6 && cur_valid !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    check(cur_o, ecur);
    check(chg_o, echg);
    if (cur_valid !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic t_sample(input logic [3:0] s, input ctc_temp_type raw,
                          input ctc_temp_type exp);
    int n;
    @(posedge clock_i);
    traw   <= raw;
    tsrc   <= s;
    tvalid <= 1'b1;
    @(posedge clock_i);
    tvalid <= 1'b0;
    // The result pulse stands only in the cycle after the sample edge
    #1;
    for (n = 0; n < 6 && tvalid_o !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    check({16'h0, temp_o}, {16'h0, exp});
    check({28'h0, tsrc_o}, {28'h0, s});
    if (tvalid_o !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    sys_rst_i <= 1'b1;
    {awaddr, araddr, wdata, wstrb, cc_count, traw, tsrc} <= '0;
    {awvalid, wvalid, bready, arvalid, rready, cc_valid, tvalid} <= '0;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h1, 2'h0);
    rd(8'h08, 32'h3f800000, 2'h0);
    rd(8'h0c, 32'h3f800000, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h18, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h0);
    rd(8'h44, 32'h0, 2'h0);
    rd(8'h4c, 32'h0, 2'h2);
    rd(8'h02, 32'h0, 2'h2);
    wr(8'h14, 32'h1234, 4'hf, 2'h2);
    wr(8'h80, 32'h1234, 4'hf, 2'h2);
    // Reset gains are 1.0 with no shift: the count passes through unchanged
    cc_sample(32'sd1000, 32'sd1000, 32'sd1000);
    cc_sample(32'ha0000000, 32'ha0000000, 32'ha00003e8);
    wr(8'h00, 32'd100, 4'hf, 2'h0);
    wr(8'h04, 32'd4, 4'hf, 2'h0);
    // Gain 1.5 stands for a sense resistor near 4.98 milliohm
    wr(8'h08, 32'h3fc00000, 4'hf, 2'h0);
    wr(8'h0c, 32'h48da740e, 4'hf, 2'h0);
    // Lane 0 only: current shift 1, capacity shift untouched
    wr(8'h10, 32'h00000101, 4'h1, 2'h0);
    rd(8'h10, 32'h00000001, 2'h0);
    rd(8'h0c, 32'h48da740e, 2'h0);
    wr(8'h18, 32'h0, 4'hf, 2'h0);
    repeat (4) @(posedge clock_i);
    cc_sample(32'sd1000, 32'sd731, 32'sd436207626);
    cc_sample(-32'sd1000, -32'sd768, -32'sd22369622);
    wr(8'h04, 32'd0, 4'hf, 2'h0);
    repeat (4) @(posedge clock_i);
    cc_sample(32'sd1000, 32'sd675, 32'sd380283571);
    rd(8'h18, 32'sd380283571, 2'h0);
    rd(8'h14, 32'sd675, 2'h0);
    wr(8'h18, 32'h0, 4'hf, 2'h0);
    rd(8'h18, 32'h0, 2'h0);
    // A current gain with a zero exponent yields no current
    wr(8'h08, 32'h00400000, 4'hf, 2'h0);
    repeat (2) @(posedge clock_i);
    cc_sample(32'sd101, 32'sd0, 32'sd447392);
    for (i = 0; i < 10; i++) begin
      ofs = 16'(i * 7 - 20);
      wr(8'h20 + 8'(4 * i), {16'h0, ofs}, 4'hf, 2'h0);
    end
    repeat (2) @(posedge clock_i);
    for (i = 0; i <= 10; i++) begin
      ofs = (i < 10) ? 16'(i * 7 - 20) : 16'h0;
      t_sample(4'(i), 16'd2950, 16'd2950 + ofs);
    end
    t_sample(4'h0, 16'd5, 16'hfff1);
    tally_and_finish();
  end
endmodule // current_temp_calibration_tb_top
`default_nettype wire
